/* File: dv/sfr_bank_props.sv */
// port checks of the register bank: read masks, program counter, sleep.
// assumes it is bound to sfr_bank and that strobes last one cycle.
`timescale 1ns/10ps
module sfr_bank_props #(
	parameter int unsigned STACK_DEPTH = 5,
	parameter int unsigned WDT_CNT_W = 16,
	parameter logic [WDT_CNT_W-1:0] WDT_BASE_CYCLES = 16'h1200
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// inputs of the bank
	input wire logic core_type_option,
	input wire logic enhanced_option,
	input wire sfr_pkg::sfr_req_s req,
	input wire sfr_pkg::sfr_cmd_s cmd,
	input wire logic [5:0] pin_i,
	// outputs of the bank
	input wire logic [7:0] rdata,
	input wire logic [9:0] pc,
	input wire sfr_pkg::sfr_pad_s pad,
	input wire logic irq_req,
	input wire logic wake,
	input wire logic wdt_timeout,
	input wire logic asleep
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	logic rd0;
	logic rd1;
	logic pcc;
	assign rd0 = req.rd && !req.ioc_page;
	assign rd1 = req.rd && req.ioc_page;
	assign pcc = cmd.call_instruction || cmd.irq_entry || cmd.jump_instruction;

	AST_PC_INIT: assert property ($fell(sys_rst) |=>
		pc == (core_type_option ? 10'h000 : 10'h3ff))
		else $error("pc after reset");
	AST_CALL_LOAD: assert property (cmd.call_instruction |=>
		pc == $past(cmd.target)) else $error("call target");
	AST_JUMP_LOAD: assert property (cmd.jump_instruction &&
		!cmd.call_instruction && !cmd.irq_entry |=> pc == $past(cmd.target))
		else $error("jump target");
	AST_CALL_RET: assert property (cmd.call_instruction ##1
		(cmd.return_instruction && !pcc) |=> pc == $past(pc, 2) + 10'h001)
		else $error("return address");
	AST_ISR_HI: assert property (rd0 && req.addr == sfr_pkg::A_ISR |=>
		rdata[7:3] == 5'h00) else $error("flag high bits");
	AST_PTR_HI: assert property (rd0 && req.addr == sfr_pkg::A_PTR |=>
		rdata[7:6] == 2'h3) else $error("pointer high bits");
	AST_DIR_HI: assert property (rd1 && req.addr == sfr_pkg::A_IOC_DIR |=>
		rdata[7:6] == 2'h3) else $error("direction high bits");
	AST_WDC_ZERO: assert property ((rd0 && req.addr == sfr_pkg::A_WDC) ||
		(rd1 && req.addr == sfr_pkg::A_IOC_WDC) |=> rdata[5:3] == 3'h0)
		else $error("watchdog control bits");
	AST_SLEEP_SET: assert property ($rose(asleep) |->
		$past(cmd.sleep_instruction)) else $error("sleep without command");
	AST_WAKE_SLEEP: assert property (wake |-> $past(asleep) && !asleep)
		else $error("wake while awake");
	cover property (cmd.call_instruction ##1 cmd.return_instruction);
	cover property (wake);
	cover property (wdt_timeout);
endmodule : sfr_bank_props

/* File: dv/sfr_bank_tb.sv */
// self-checking bench of the register bank, one task per scenario.
// assumes the bank and its checker are compiled before this file.
`timescale 1ns/10ps
module sfr_bank_tb;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic core_type_option = 1'b0;
	logic enhanced_option = 1'b0;
	sfr_pkg::sfr_req_s req = '0;
	sfr_pkg::sfr_cmd_s cmd = '0;
	logic [5:0] pin_i = 6'h00;
	logic [7:0] rdata;
	logic [9:0] pc;
	sfr_pkg::sfr_pad_s pad;
	logic irq_req;
	logic wake;
	logic wdt_timeout;
	logic asleep;
	logic [7:0] v;
	int miscompares = 0;
	int n_compared = 0;
	int i;

	initial begin
		forever #2 ref_clk = ~ref_clk;
	end

	sfr_bank #(.WDT_BASE_CYCLES(16'h0010)) u_sfr_bank (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.core_type_option(core_type_option),
		.enhanced_option(enhanced_option),
		.req(req),
		.rdata(rdata),
		.cmd(cmd),
		.pc(pc),
		.pin_i(pin_i),
		.pad(pad),
		.irq_req(irq_req),
		.wake(wake),
		.wdt_timeout(wdt_timeout),
		.asleep(asleep)
	);

	task automatic tally_and_finish;
		$display("compared %0d, wrong %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [9:0] s, input logic [9:0] e, string m);
		n_compared++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick

	task automatic setpin(input logic [5:0] p);
		tick(1);
		pin_i = p;
		tick(6);
	endtask : setpin

	task automatic wr(input logic pg, input logic [5:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#1 req = {1'b1, 1'b0, pg, a, d};
		@(posedge ref_clk);
		#1 req = '0;
	endtask : wr

	task automatic rd(input logic pg, input logic [5:0] a);
		@(posedge ref_clk);
		#1 req = {1'b0, 1'b1, pg, a, 8'h00};
		@(posedge ref_clk);
		#1 req = '0;
		v = rdata;
	endtask : rd

	task automatic rdc(input logic pg, input logic [5:0] a, input logic [7:0] e,
		string m);
		rd(pg, a);
		chk(v, e, m);
	endtask : rdc

	// two event words on consecutive edges: sleep 200, clear 100,
	// disable 080, enable 040, jump 008, call 004, return 002
	task automatic ev(input logic [19:0] c1, input logic [19:0] c2);
		@(posedge ref_clk);
		#1 cmd = c1;
		@(posedge ref_clk);
		#1 cmd = c2;
		@(posedge ref_clk);
		#1 cmd = '0;
	endtask : ev

	task automatic do_reset(input logic ct);
		sys_rst = 1'b1;
		core_type_option = ct;
		pin_i = 6'h00;
		repeat (20) @(posedge ref_clk);
		#1 sys_rst = 1'b0;
		tick(2);
		chk(pc, ct ? 10'h000 : 10'h3ff, "pc after reset");
	endtask : do_reset

	task automatic s_regs;
		rdc(1'b0, sfr_pkg::A_STAT, 8'h18, "status reset");
		rdc(1'b0, sfr_pkg::A_PTR, 8'hc0, "pointer reset");
		rdc(1'b1, sfr_pkg::A_IOC_DIR, 8'hff, "direction reset");
		rdc(1'b0, sfr_pkg::A_ISR, 8'h00, "flags reset");
		rdc(1'b1, 6'h02, 8'h00, "reserved read");
		wr(1'b0, sfr_pkg::A_PTR, 8'h3f);
		rdc(1'b0, sfr_pkg::A_PTR, 8'hff, "pointer ones");
		wr(1'b0, sfr_pkg::A_PTR, 8'h00);
		rdc(1'b0, sfr_pkg::A_PTR, 8'hc0, "pointer zeros");
	endtask : s_regs

	task automatic s_port;
		wr(1'b1, sfr_pkg::A_IOC_DIR, 8'h00);
		rdc(1'b1, sfr_pkg::A_IOC_DIR, 8'hc0, "direction read");
		chk(pad.oe, 6'h3f, "all pins drive");
		wr(1'b1, sfr_pkg::A_IOC_WDC, 8'h7f);
		rdc(1'b0, sfr_pkg::A_WDC, 8'h47, "watchdog control");
		chk(pad.oe, 6'h3e, "pin zero as input");
		wr(1'b1, sfr_pkg::A_IOC_WDC, 8'h00);
		wr(1'b0, sfr_pkg::A_PD, 8'h00);
		chk(pad.pull_down_en, 6'h3f, "all pull-downs");
		wr(1'b0, sfr_pkg::A_PD, 8'h8f);
		wr(1'b1, sfr_pkg::A_IOC_WDC, 8'h07);
		chk(pad.pull_down_en, 6'h07, "low pull-downs");
		wr(1'b1, sfr_pkg::A_IOC_WDC, 8'h00);
		enhanced_option = 1'b1;
		#1 chk(pad.pull_down_en, 6'h07, "enhanced storage");
		enhanced_option = 1'b0;
		wr(1'b0, sfr_pkg::A_PH, 8'h00);
		chk(pad.pull_up_en, 6'h37, "pull-ups");
		wr(1'b0, sfr_pkg::A_PORT, 8'h3f);
		chk(pad.o, 6'h3f, "port outputs");
		wr(1'b0, sfr_pkg::A_OD, 8'hff);
		chk(pad.oe, 6'h08, "open-drain high");
		wr(1'b0, sfr_pkg::A_OD, 8'h00);
		chk(pad.oe, 6'h3f, "push-pull");
	endtask : s_port

	task automatic s_pc;
		ev({10'h008, 10'h100}, 20'h00000);
		chk(pc, 10'h100, "jump");
		ev({10'h004, 10'h123}, {10'h002, 10'h000});
		chk(pc, 10'h101, "call and return");
		wr(1'b0, sfr_pkg::A_PCH, 8'hfe);
		wr(1'b0, sfr_pkg::A_PC, 8'h34);
		chk(pc, 10'h234, "pc write high bits");
		ev({10'h010, 10'h050}, {10'h020, 10'h000});
		chk(pc, 10'h235, "entry and return");
		rdc(1'b1, sfr_pkg::A_IOC_CTL, 8'h7f, "return enables");
		ev({10'h001, 10'h000}, {10'h001, 10'h000});
		chk(pc, 10'h237, "two steps");
	endtask : s_pc

	task automatic s_timer;
		wr(1'b1, sfr_pkg::A_IOC_CTL, 8'h02);
		wr(1'b0, sfr_pkg::A_TMR, 8'h00);
		tick(80);
		rd(1'b0, sfr_pkg::A_TMR);
		chk(v >= 8'h09 && v <= 8'h0b, 1'b1, "divide by eight");
		wr(1'b1, sfr_pkg::A_IOC_CTL, 8'h08);
		wr(1'b0, sfr_pkg::A_TMR, 8'h00);
		tick(20);
		rd(1'b0, sfr_pkg::A_TMR);
		chk(v >= 8'h14 && v <= 8'h16, 1'b1, "no prescale");
		for (int te = 0; te < 2; te++) begin
			wr(1'b1, sfr_pkg::A_IOC_CTL, te ? 8'h38 : 8'h28);
			wr(1'b0, sfr_pkg::A_TMR, 8'h00);
			repeat (3) begin
				setpin(6'h04);
				setpin(6'h00);
			end
			rdc(1'b0, sfr_pkg::A_TMR, 8'h03, "pin edges");
		end
		wr(1'b1, sfr_pkg::A_IOC_CTL, 8'h08);
		wr(1'b1, sfr_pkg::A_IOC_IMR, 8'h01);
		wr(1'b0, sfr_pkg::A_TMR, 8'hf0);
		tick(30);
		rdc(1'b0, sfr_pkg::A_ISR, 8'h01, "overflow flag");
	endtask : s_timer

	task automatic s_irq;
		wr(1'b1, sfr_pkg::A_IOC_IMR, 8'h07);
		setpin(6'h02);
		rdc(1'b0, sfr_pkg::A_ISR, 8'h02, "change flag");
		wr(1'b1, sfr_pkg::A_IOC_IMR, 8'hfd);
		rdc(1'b0, sfr_pkg::A_ISR, 8'h00, "masked read");
		rdc(1'b1, sfr_pkg::A_IOC_IMR, 8'hfd, "mask storage");
		wr(1'b1, sfr_pkg::A_IOC_IMR, 8'h07);
		ev({10'h040, 10'h000}, 20'h00000);
		rdc(1'b1, sfr_pkg::A_IOC_CTL, 8'h7f, "enable bit");
		chk(irq_req, 1'b1, "request");
		ev({10'h080, 10'h000}, 20'h00000);
		rdc(1'b1, sfr_pkg::A_IOC_CTL, 8'h3f, "disable bit");
		chk(irq_req, 1'b0, "no request");
		wr(1'b0, sfr_pkg::A_ISR, 8'h00);
		wr(1'b0, sfr_pkg::A_ISR, 8'hff);
		rdc(1'b0, sfr_pkg::A_ISR, 8'h00, "write cannot set");
		wr(1'b1, sfr_pkg::A_IOC_IMR, 8'h04);
		wr(1'b1, sfr_pkg::A_IOC_WDC, 8'h47);
		setpin(6'h03);
		rd(1'b0, sfr_pkg::A_PORT);
		chk(v[0], 1'b1, "pin zero level");
		setpin(6'h02);
		rdc(1'b0, sfr_pkg::A_ISR, 8'h04, "falling edge");
		wr(1'b0, sfr_pkg::A_ISR, 8'h00);
		wr(1'b1, sfr_pkg::A_IOC_WDC, 8'h07);
		setpin(6'h03);
		setpin(6'h02);
		rdc(1'b0, sfr_pkg::A_ISR, 8'h00, "path masked");
	endtask : s_irq

	task automatic s_sleep;
		ev({10'h200, 10'h000}, 20'h00000);
		chk(asleep, 1'b1, "asleep");
		rdc(1'b0, sfr_pkg::A_STAT, 8'h10, "status in sleep");
		tick(1);
		pin_i = 6'h0a;
		for (i = 0; i < 10 && wake !== 1'b1; i++) tick(1);
		chk(wake, 1'b1, "wake pulse");
		if (wake !== 1'b1) tally_and_finish();
		rdc(1'b0, sfr_pkg::A_STAT, 8'h90, "wake cause");
		ev({10'h100, 10'h000}, 20'h00000);
		rd(1'b0, sfr_pkg::A_STAT);
		chk(v[4:3], 2'h3, "watchdog clear");
		wr(1'b1, sfr_pkg::A_IOC_WDC, 8'h87);
		for (i = 0; i < 5000 && wdt_timeout !== 1'b1; i++) tick(1);
		chk(wdt_timeout, 1'b1, "watchdog timeout");
		if (wdt_timeout !== 1'b1) tally_and_finish();
		wr(1'b1, sfr_pkg::A_IOC_WDC, 8'h07);
		rd(1'b0, sfr_pkg::A_STAT);
		chk({v[7], v[4]}, 2'h0, "status after timeout");
	endtask : s_sleep

	initial begin
		do_reset(1'b0);
		s_regs();
		s_port();
		s_pc();
		s_timer();
		do_reset(1'b1);
		s_irq();
		s_sleep();
		tally_and_finish();
	end
endmodule : sfr_bank_tb

bind sfr_bank sfr_bank_props #(
	.STACK_DEPTH(STACK_DEPTH),
	.WDT_CNT_W(WDT_CNT_W),
	.WDT_BASE_CYCLES(WDT_BASE_CYCLES)
) u_sfr_bank_props (
	.ref_clk(ref_clk),
	.sys_rst(sys_rst),
	.core_type_option(core_type_option),
	.enhanced_option(enhanced_option),
	.req(req),
	.cmd(cmd),
	.pin_i(pin_i),
	.rdata(rdata),
	.pc(pc),
	.pad(pad),
	.irq_req(irq_req),
	.wake(wake),
	.wdt_timeout(wdt_timeout),
	.asleep(asleep)
);

/* File: verilog/sfr_bank.sv */
// special function register bank of an 8-bit core: status word, pointer,
// port six control, interrupt flags and mask, timer, watchdog, program
// counter and stack, and the general registers behind them.
// assumes ref_clk is the instruction-cycle clock and the core decodes
// instructions into the request and event strobes seen here.
`timescale 1ns/10ps

// Overview of operation
// RQ1: timeout bit set by sleep or clear; powerdown bit cleared by sleep
// RQ2: wake cause bit reads 1 after pin-change wake, 0 after other resets
// RQ3: pointer low six bits select address 0x00-0x3F; top two read one
// RQ4: flags set by falling external edge, port change, timer overflow
// RQ5: software writes may clear interrupt flags but never set them
// RQ6: status register reads as stored flags AND mask bits
// RQ7: mask bits 2..0 enable external, pin-change, timer interrupts
// RQ8: global enable cleared by disable or entry, set by enable or return
// RQ9: timer counts cycles, or pin rising/falling edges by edge select
// RQ10: prescaler serves the timer when assign bit is 0, watchdog when 1
// RQ11: ratio n divides timer by 2^(n+1), watchdog by 2^n
// RQ12: prescaler cleared only by a write to the timer counter
// RQ13: direction 0 drives pin, 1 floats it; top two bits read one
// RQ14: pull-down register bits 6..4 low enable pull-downs on pins 2..0
// RQ15: open-drain bits 5,4,2,1,0 select open-drain when set
// RQ16: pull-high bits 5,4,2,1,0 low enable pull-ups
// RQ17: watchdog control bit 7 enables the watchdog; bits 5..3 read zero
// RQ18: pin select routes pin 0 to interrupt path, else path masked
// RQ19: without enhanced option watchdog bits 2..0 enable pull-downs 5..3
// RQ20: program counter resets to zero for core type 1, 3FF otherwise
// RQ21: jump and call load ten bits, call pushes next, return pops
// RQ22: core type 0 program counter writes take A8, A9 from buffer
// RQ23: core type 1 keeps pin-change interrupt and wake always enabled
// RQ24: high buffer bit 1 holds pc bit 9, bit 0 holds pc bit 8
module sfr_bank #(
	parameter int unsigned STACK_DEPTH = 5,
	parameter int unsigned WDT_CNT_W = 16,
	parameter logic [WDT_CNT_W-1:0] WDT_BASE_CYCLES = 16'h1200
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// option straps
	input wire logic core_type_option,
	input wire logic enhanced_option,
	// register access
	input wire sfr_pkg::sfr_req_s req,
	output logic [7:0] rdata,
	// instruction events
	input wire sfr_pkg::sfr_cmd_s cmd,
	output logic [9:0] pc,
	// port six pins
	input wire logic [5:0] pin_i,
	output sfr_pkg::sfr_pad_s pad,
	// core status
	output logic irq_req,
	output logic wake,
	output logic wdt_timeout,
	output logic asleep
);

	typedef struct packed {
		logic init;
		logic [2:0] arm;
		logic [9:0] pc;
		logic [STACK_DEPTH-1:0][9:0] stack;
		logic [7:0] status;
		logic [7:0] ptr;
		logic [7:0] tmr;
		logic [7:0] gp5;
		logic [7:0] port;
		logic [7:0] gp7;
		logic [7:0] wdc;
		logic [7:0] gp9;
		logic [7:0] pch;
		logic [7:0] pd;
		logic [7:0] od;
		logic [7:0] ph;
		logic [7:0] imr;
		logic [2:0] flags;
		logic [7:0] ctl;
		logic [7:0] dir;
		logic [5:0] sync1;
		logic [5:0] sync2;
		logic [5:0] pin_prev;
		logic asleep;
		logic [WDT_CNT_W-1:0] wdt_cnt;
		logic wake;
		logic timeout;
		logic [7:0] rdata;
		logic [sfr_pkg::RAM_N-1:0][7:0] ram;
	} sfr_st_s;

	sfr_st_s s_q;
	sfr_st_s s_d;

	logic [5:0] ea;
	logic [5:0] chg_en;
	logic [5:0] chg;
	logic pin_edge;
	logic src_tick;
	logic base_tick;
	logic pre_in;
	logic pre_tick;
	logic tmr_tick;
	logic wdt_tick;
	logic tmr_wr;
	logic pc_wr;
	logic ext_fall;
	logic [2:0] events;
	logic [9:0] pc_inc;

	// indirect access goes through the pointer's low six bits
	function automatic logic [5:0] eff_addr(
		input logic [5:0] a,
		input logic [7:0] p
	);
		eff_addr = (a == sfr_pkg::A_IND) ? p[5:0] : a; // RQ3
	endfunction : eff_addr

	// read value of one register
	function automatic logic [7:0] read_reg(
		input sfr_st_s s,
		input logic ioc,
		input logic [5:0] a
	);
		read_reg = 8'h00;
		if (ioc) begin
			case (a)
				sfr_pkg::A_IOC_CTL: read_reg = s.ctl;
				sfr_pkg::A_IOC_DIR: read_reg = s.dir | sfr_pkg::HI_ONES; // RQ13
				sfr_pkg::A_PD: read_reg = s.pd;
				sfr_pkg::A_OD: read_reg = s.od;
				sfr_pkg::A_PH: read_reg = s.ph;
				sfr_pkg::A_IOC_WDC: read_reg = s.wdc & ~sfr_pkg::WD_ZERO; // RQ17
				sfr_pkg::A_IOC_IMR: read_reg = s.imr;
				default: read_reg = 8'h00;
			endcase
		end else begin
			case (a)
				sfr_pkg::A_TMR: read_reg = s.tmr;
				sfr_pkg::A_PC: read_reg = s.pc[7:0];
				sfr_pkg::A_STAT: read_reg = s.status;
				sfr_pkg::A_PTR: read_reg = s.ptr | sfr_pkg::HI_ONES; // RQ3
				sfr_pkg::A_GP5: read_reg = s.gp5;
				// pins read back as their synchronised level
				sfr_pkg::A_PORT: read_reg = {s.port[7:6], s.sync2}; // RQ18
				sfr_pkg::A_GP7: read_reg = s.gp7;
				sfr_pkg::A_WDC: read_reg = s.wdc & ~sfr_pkg::WD_ZERO; // RQ17
				sfr_pkg::A_GP9: read_reg = s.gp9;
				sfr_pkg::A_PCH: read_reg = s.pch;
				sfr_pkg::A_PD: read_reg = s.pd;
				sfr_pkg::A_OD: read_reg = s.od;
				sfr_pkg::A_PH: read_reg = s.ph;
				sfr_pkg::A_IMR: read_reg = s.imr;
				sfr_pkg::A_ISR: read_reg = {5'h00, s.flags & s.imr[2:0]}; // RQ6
				default: begin
					if (a >= sfr_pkg::A_RAM)
						read_reg = s.ram[a - sfr_pkg::A_RAM];
				end
			endcase
		end
	endfunction : read_reg

	// watchdog base period, only while the watchdog is enabled
	assign base_tick = s_q.wdc[sfr_pkg::WD_EN]
		&& (s_q.wdt_cnt == WDT_BASE_CYCLES - WDT_CNT_W'(1)); // RQ17

	// timer source: cycle clock or selected edge on the timer pin
	assign pin_edge = s_q.ctl[sfr_pkg::CT_TE]
		? (s_q.pin_prev[sfr_pkg::TMR_PIN] && !s_q.sync2[sfr_pkg::TMR_PIN])
		: (!s_q.pin_prev[sfr_pkg::TMR_PIN] && s_q.sync2[sfr_pkg::TMR_PIN]);
	assign src_tick = s_q.ctl[sfr_pkg::CT_TS]
		? (pin_edge && s_q.arm[2]) : 1'b1; // RQ9

	// shared prescaler sits in front of timer or watchdog
	assign pre_in = s_q.ctl[sfr_pkg::CT_PAB] ? base_tick : src_tick; // RQ10
	assign tmr_tick = s_q.ctl[sfr_pkg::CT_PAB] ? src_tick : pre_tick; // RQ10
	assign wdt_tick = s_q.ctl[sfr_pkg::CT_PAB] ? pre_tick : base_tick;

	assign ea = eff_addr(req.addr, s_q.ptr);
	assign tmr_wr = req.wr && !req.ioc_page && (ea == sfr_pkg::A_TMR);
	assign pc_wr = req.wr && !req.ioc_page && (ea == sfr_pkg::A_PC);
	assign pc_inc = s_q.pc + 10'h001;

	// change detection is held off until the synchroniser has filled
	assign chg_en = core_type_option ? 6'h3f : s_q.gp9[5:0]; // RQ23
	assign chg = (s_q.sync2 ^ s_q.pin_prev) & chg_en
		& {6{s_q.arm[2]}};
	assign ext_fall = s_q.wdc[sfr_pkg::WD_EIS] && s_q.arm[2]
		&& s_q.pin_prev[0] && !s_q.sync2[0]; // RQ18

	assign events = {ext_fall, |chg,
		tmr_tick && !tmr_wr && (s_q.tmr == 8'hff)}; // RQ4

	sfr_prescaler u_pre (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.tick_in(pre_in),
		.clear(tmr_wr),
		.to_wdt(s_q.ctl[sfr_pkg::CT_PAB]),
		.ratio(s_q.ctl[2:0]),
		.div_tick(pre_tick)
	);

	always_comb begin
		s_d = s_q;
		s_d.sync1 = pin_i;
		s_d.sync2 = s_q.sync1;
		s_d.pin_prev = s_q.sync2;
		s_d.arm = {s_q.arm[1:0], 1'b1};
		s_d.wake = 1'b0;
		s_d.timeout = 1'b0;

		// register writes
		if (req.wr) begin
			case ({req.ioc_page, ea})
				{1'b0, sfr_pkg::A_TMR}: s_d.tmr = req.wdata;
				{1'b0, sfr_pkg::A_STAT}: begin
					s_d.status = (req.wdata & sfr_pkg::ST_WR_MASK)
						| (s_q.status & ~sfr_pkg::ST_WR_MASK);
				end
				{1'b0, sfr_pkg::A_PTR}: s_d.ptr = req.wdata | sfr_pkg::HI_ONES;
				{1'b0, sfr_pkg::A_GP5}: s_d.gp5 = req.wdata;
				{1'b0, sfr_pkg::A_PORT}: s_d.port = req.wdata;
				{1'b0, sfr_pkg::A_GP7}: s_d.gp7 = req.wdata;
				{1'b0, sfr_pkg::A_WDC},
				{1'b1, sfr_pkg::A_IOC_WDC}: begin
					s_d.wdc = req.wdata & ~sfr_pkg::WD_ZERO; // RQ17
				end
				{1'b0, sfr_pkg::A_GP9}: s_d.gp9 = req.wdata;
				{1'b0, sfr_pkg::A_PCH}: s_d.pch = req.wdata; // RQ24
				{1'b0, sfr_pkg::A_PD},
				{1'b1, sfr_pkg::A_PD}: s_d.pd = req.wdata;
				{1'b0, sfr_pkg::A_OD},
				{1'b1, sfr_pkg::A_OD}: s_d.od = req.wdata;
				{1'b0, sfr_pkg::A_PH},
				{1'b1, sfr_pkg::A_PH}: s_d.ph = req.wdata;
				{1'b0, sfr_pkg::A_IMR},
				{1'b1, sfr_pkg::A_IOC_IMR}: s_d.imr = req.wdata; // RQ7
				{1'b0, sfr_pkg::A_ISR}: begin
					s_d.flags = s_q.flags & req.wdata[2:0]; // RQ5
				end
				{1'b1, sfr_pkg::A_IOC_CTL}: s_d.ctl = req.wdata;
				{1'b1, sfr_pkg::A_IOC_DIR}: begin
					s_d.dir = req.wdata | sfr_pkg::HI_ONES; // RQ13
				end
				default: begin
					if (!req.ioc_page && ea >= sfr_pkg::A_RAM)
						s_d.ram[ea - sfr_pkg::A_RAM] = req.wdata;
				end
			endcase
		end

		// timer counter: a write wins over a count
		if (!tmr_wr && tmr_tick)
			s_d.tmr = s_q.tmr + 8'h01; // RQ9

		// hardware sets win over a clear in the same cycle
		s_d.flags = s_d.flags | events; // RQ4

		// global interrupt enable
		if (cmd.irq_disable_instruction || cmd.irq_entry)
			s_d.ctl[sfr_pkg::CT_GIE] = 1'b0; // RQ8
		if (cmd.irq_enable_instruction || cmd.return_from_irq_instruction)
			s_d.ctl[sfr_pkg::CT_GIE] = 1'b1; // RQ8

		// watchdog base counter
		if (cmd.watchdog_clear_instruction || base_tick
			|| !s_q.wdc[sfr_pkg::WD_EN])
			s_d.wdt_cnt = '0;
		else
			s_d.wdt_cnt = s_q.wdt_cnt + WDT_CNT_W'(1);

		// sleep, watchdog clear, wake and timeout
		if (cmd.sleep_instruction) begin
			s_d.status[sfr_pkg::ST_TO] = 1'b1; // RQ1
			s_d.status[sfr_pkg::ST_PD] = 1'b0; // RQ1
			s_d.asleep = 1'b1;
		end
		if (cmd.watchdog_clear_instruction) begin
			s_d.status[sfr_pkg::ST_TO] = 1'b1; // RQ1
			s_d.status[sfr_pkg::ST_PD] = 1'b1; // RQ1
		end
		if (s_q.asleep && |chg) begin
			s_d.status[sfr_pkg::ST_WAKE] = 1'b1; // RQ2
			s_d.asleep = 1'b0;
			s_d.wake = 1'b1;
		end
		if (wdt_tick && s_q.wdc[sfr_pkg::WD_EN]) begin
			s_d.status[sfr_pkg::ST_TO] = 1'b0; // RQ1
			s_d.status[sfr_pkg::ST_WAKE] = 1'b0; // RQ2
			s_d.asleep = 1'b0;
			s_d.timeout = 1'b1;
		end

		// program counter and stack
		if (s_q.init) begin
			s_d.init = 1'b0;
			s_d.pc = core_type_option ? sfr_pkg::PC_ZERO
				: sfr_pkg::PC_ONES; // RQ20
		end else if (cmd.call_instruction || cmd.irq_entry) begin
			s_d.stack = {s_q.stack[STACK_DEPTH-2:0], pc_inc}; // RQ21
			s_d.pc = cmd.target; // RQ21
		end else if (cmd.jump_instruction) begin
			s_d.pc = cmd.target; // RQ21
		end else if (cmd.return_instruction
			|| cmd.return_from_irq_instruction) begin
			s_d.pc = s_q.stack[0]; // RQ21
			s_d.stack = {s_q.stack[STACK_DEPTH-1],
				s_q.stack[STACK_DEPTH-1:1]};
		end else if (pc_wr) begin
			if (!core_type_option)
				s_d.pc = {s_q.pch[1:0], req.wdata}; // RQ22
			else if (enhanced_option)
				s_d.pc = {2'b00, req.wdata};
			else
				s_d.pc = {s_q.pc[9:8], req.wdata};
		end else if (cmd.pc_step) begin
			s_d.pc = pc_inc;
		end

		if (req.rd)
			s_d.rdata = read_reg(s_q, req.ioc_page, ea);
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.init <= 1'b1;
			s_q.status <= sfr_pkg::RST_STAT; // RQ1
			s_q.ptr <= sfr_pkg::RST_PTR;
			s_q.ctl <= sfr_pkg::RST_CTL;
			s_q.dir <= sfr_pkg::RST_DIR;
			s_q.pd <= sfr_pkg::RST_PULL;
			s_q.ph <= sfr_pkg::RST_PULL;
			s_q.od <= sfr_pkg::RST_OD;
			s_q.wdc <= sfr_pkg::RST_WDC;
			s_q.imr <= sfr_pkg::RST_ZERO;
		end else begin
			s_q <= s_d;
		end
	end

	// pads: open drain drives only a low level
	always_comb begin
		pad.o = s_q.port[5:0] & ~(s_q.od[5:0] & sfr_pkg::OD_PINS); // RQ15
		pad.oe = ~s_q.dir[5:0]
			& ~(s_q.od[5:0] & sfr_pkg::OD_PINS & s_q.port[5:0]); // RQ13
		if (s_q.wdc[sfr_pkg::WD_EIS])
			pad.oe[0] = 1'b0; // RQ18
		pad.pull_down_en[2:0] = ~s_q.pd[6:4]; // RQ14
		pad.pull_down_en[5:3] = enhanced_option ? 3'b000
			: ~s_q.wdc[2:0]; // RQ19
		pad.pull_up_en = ~s_q.ph[5:0] & sfr_pkg::PU_PINS; // RQ16
	end

	assign irq_req = s_q.ctl[sfr_pkg::CT_GIE]
		&& |(s_q.flags & s_q.imr[2:0]); // RQ7
	assign rdata = s_q.rdata;
	assign pc = s_q.pc;
	assign wake = s_q.wake;
	assign wdt_timeout = s_q.timeout;
	assign asleep = s_q.asleep;

endmodule : sfr_bank

/* File: verilog/sfr_pkg.sv */
// register map, field positions, reset values and carriers of the special
// function register bank; shared by the bank and its prescaler.
// assumes an 8-bit core that runs one instruction cycle per ref_clk edge.
package sfr_pkg;

	localparam int unsigned DATA_W = 8;
	localparam int unsigned ADDR_W = 6;
	localparam int unsigned PC_W = 10;
	localparam int unsigned PIN_N = 6;
	localparam int unsigned PRE_W = 8;

	// register page addresses
	localparam logic [5:0] A_IND = 6'h00;
	localparam logic [5:0] A_TMR = 6'h01;
	localparam logic [5:0] A_PC = 6'h02;
	localparam logic [5:0] A_STAT = 6'h03;
	localparam logic [5:0] A_PTR = 6'h04;
	localparam logic [5:0] A_GP5 = 6'h05;
	localparam logic [5:0] A_PORT = 6'h06;
	localparam logic [5:0] A_GP7 = 6'h07;
	localparam logic [5:0] A_WDC = 6'h08;
	localparam logic [5:0] A_GP9 = 6'h09;
	localparam logic [5:0] A_PCH = 6'h0a;
	localparam logic [5:0] A_PD = 6'h0b;
	localparam logic [5:0] A_OD = 6'h0c;
	localparam logic [5:0] A_PH = 6'h0d;
	localparam logic [5:0] A_IMR = 6'h0e;
	localparam logic [5:0] A_ISR = 6'h0f;
	localparam logic [5:0] A_RAM = 6'h10;
	localparam int unsigned RAM_N = 48;

	// control page addresses
	localparam logic [5:0] A_IOC_CTL = 6'h01;
	localparam logic [5:0] A_IOC_DIR = 6'h06;
	localparam logic [5:0] A_IOC_WDC = 6'h0e;
	localparam logic [5:0] A_IOC_IMR = 6'h0f;

	// field positions
	localparam int unsigned ST_WAKE = 7;
	localparam int unsigned ST_TO = 4;
	localparam int unsigned ST_PD = 3;
	localparam int unsigned CT_GIE = 6;
	localparam int unsigned CT_TS = 5;
	localparam int unsigned CT_TE = 4;
	localparam int unsigned CT_PAB = 3;
	localparam int unsigned WD_EN = 7;
	localparam int unsigned WD_EIS = 6;
	localparam int unsigned FL_EXT = 2;
	localparam int unsigned FL_PIN = 1;
	localparam int unsigned FL_TMR = 0;
	localparam int unsigned TMR_PIN = 2;

	// masks
	localparam logic [7:0] ST_WR_MASK = 8'h67;
	localparam logic [7:0] HI_ONES = 8'hc0;
	localparam logic [7:0] WD_ZERO = 8'h38;
	localparam logic [5:0] OD_PINS = 6'h37;
	localparam logic [5:0] PU_PINS = 6'h37;

	// reset values
	localparam logic [7:0] RST_STAT = 8'h18;
	localparam logic [7:0] RST_PTR = 8'hc0;
	localparam logic [7:0] RST_CTL = 8'h3f;
	localparam logic [7:0] RST_DIR = 8'hff;
	localparam logic [7:0] RST_PULL = 8'hff;
	localparam logic [7:0] RST_OD = 8'h00;
	localparam logic [7:0] RST_WDC = 8'h07;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [9:0] PC_ONES = 10'h3ff;
	localparam logic [9:0] PC_ZERO = 10'h000;

	// register access from the core
	typedef struct packed {
		logic wr;
		logic rd;
		logic ioc_page;
		logic [5:0] addr;
		logic [7:0] wdata;
	} sfr_req_s;

	// instruction events from the core
	typedef struct packed {
		logic sleep_instruction;
		logic watchdog_clear_instruction;
		logic irq_disable_instruction;
		logic irq_enable_instruction;
		logic return_from_irq_instruction;
		logic irq_entry;
		logic jump_instruction;
		logic call_instruction;
		logic return_instruction;
		logic pc_step;
		logic [9:0] target;
	} sfr_cmd_s;

	// pad controls of port six
	typedef struct packed {
		logic [5:0] o;
		logic [5:0] oe;
		logic [5:0] pull_down_en;
		logic [5:0] pull_up_en;
	} sfr_pad_s;

endpackage : sfr_pkg

/* File: verilog/sfr_prescaler.sv */
// shared prescaler of the timer counter and the watchdog.
// assumes tick_in is a one-cycle pulse on ref_clk; div_tick is combinational.
`timescale 1ns/10ps
module sfr_prescaler (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// control
	input wire logic tick_in,
	input wire logic clear,
	input wire logic to_wdt,
	input wire logic [2:0] ratio,
	// result
	output logic div_tick
);

	typedef struct packed {
		logic [sfr_pkg::PRE_W-1:0] cnt;
	} sfr_pre_st_s;

	sfr_pre_st_s s_q;
	sfr_pre_st_s s_d;
	logic [sfr_pkg::PRE_W-1:0] mask;

	// low bits that must all be set before the output fires
	function automatic logic [sfr_pkg::PRE_W-1:0] ratio_mask(
		input logic [2:0] n,
		input logic wdt
	);
		logic [3:0] bits;
		bits = wdt ? {1'b0, n} : ({1'b0, n} + 4'h1);
		ratio_mask = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (i < int'(bits))
				ratio_mask[i] = 1'b1;
		end
	endfunction : ratio_mask

	always_comb begin
		mask = ratio_mask(ratio, to_wdt);
		div_tick = tick_in && ((s_q.cnt & mask) == mask); // RQ11
		s_d = s_q;
		if (clear)
			s_d.cnt = '0; // RQ12
		else if (tick_in)
			s_d.cnt = s_q.cnt + 8'h01;
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

endmodule : sfr_prescaler
